/* include/ptsi_pkg.sv */
// Constants for the transmit PCM slot interface: register map, control
// and status fields, code widths and slot arithmetic sizes.
// Assumes one 32-bit register port with word-aligned byte addresses.
package ptsi_pkg;

  // Register port
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

  // Control register fields
  localparam int SLOT_LSB = 0;
  localparam int SLOT_W = 6;
  localparam int CLKSLOT_LSB = 8;
  localparam int CLKSLOT_W = 3;
  localparam int LINEAR_BIT = 12;
  localparam int EXPANDED_BIT = 13;
  localparam int PORTSEL_BIT = 14;
  localparam int ENABLE_BIT = 15;
  localparam int BAL_BYP_BIT = 16;
  localparam int RESP_BYP_BIT = 17;
  localparam int GAIN_BYP_BIT = 18;
  localparam int HPF_OFF_BIT = 19;
  localparam int CTRL_USED_W = 20;

  // Status register fields
  localparam int BUSY_BIT = 0;
  localparam int OVERRUN_BIT = 1;
  localparam int FRAMECNT_LSB = 16;
  localparam int FRAMECNT_W = 16;

  // Codes and slot geometry
  localparam int CODE_W = 16;
  localparam int CMP_W = 8;
  localparam int POS_W = 11;
  localparam int IDX_W = 4;
  localparam logic [SLOT_W-1:0] NORMAL_SLOT_MASK = 6'h1f;
  localparam logic [POS_W-1:0] BITS_COMPANDED = 11'h008;
  localparam logic [POS_W-1:0] BITS_LINEAR = 11'h010;
  localparam logic [POS_W-1:0] POS_MAX = 11'h7ff;
  localparam logic [POS_W-1:0] POS_ONE = 11'h001;
  localparam int NUM_PORTS = 2;

  // Frame timing: one code per frame
  localparam int FRAME_PERIOD_US = 125;
  localparam int FRAME_RATE_HZ = 8000;

  // Payload sent to the link: code plus the slot settings it goes out with
  localparam int PAY_W = CODE_W + SLOT_W + CLKSLOT_W + 3;

  typedef enum logic [3:0] {
    LS_IDLE = 4'b0001,
    LS_WAIT = 4'b0010,
    LS_SHIFT = 4'b0100,
    LS_DONE = 4'b1000
  } ptsi_link_state_type;

endpackage : ptsi_pkg

/* rtl/ptsi_tx_slot.sv */
// Transmit PCM slot interface: captures one code per frame from the
// transmit processor and shifts it onto one of two highway ports in the
// programmed slot. Assumes clk_sys for the register port and processor
// side, and the highway's bit clock as a separate, unrelated domain.
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - All slot positions are counted from the transmit frame sync pulse.
// - Normal mode uses a 5-bit slot number, 32 eight-bit channels.
// - Expanded mode uses a 6-bit slot number, up to 64 channels.
// - Companded coding sends 8 bits per channel, linear sends 16.
// - Each channel word is shifted out most significant bit first.
// - A 3-bit clock slot delays the slot start by 0 to 7 bit clocks.
// - Slot logic works at any bit clock from 64kHz to 4.096MHz.
// - Data is driven on exactly one of two ports, chosen by software.
// - One transmit code is requested every frame; the last staged code is sent again if none is given.
// - Linear coding bypasses the compressor, sending the 16-bit sample.
// - Each code offered while not busy is captured in an output register first.
// - Balance, response and gain sections can each be made transparent.
// - The transmit high-pass stage can be disabled for leakage tests.
// - The strobe of the selected port is low while data is driven.
module ptsi_tx_slot
  import ptsi_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  // Transmit processor side
  input wire logic [CODE_W-1:0] codeLinear,
  input wire logic [CMP_W-1:0] codeCompanded,
  input wire logic codeValid,
  output logic codeRequest,
  output logic compressorBypass,
  output logic balanceBypass,
  output logic responseBypass,
  output logic tx_gain_stageBypass,
  output logic highPassOff,
  // Highway side
  input wire logic tx_bit_clock,
  input wire logic tx_frame_sync,
  output logic pcm_out_port_a,
  output logic pcm_out_port_a_en,
  output logic slot_strobe_a_n,
  output logic pcm_out_port_b,
  output logic pcm_out_port_b_en,
  output logic slot_strobe_b_n
);

  // ---------------- System clock domain ----------------
  logic [CTRL_USED_W-1:0] ctrl_q;
  logic [31:0] rdData_q;
  logic [CODE_W-1:0] holdCode_q;
  logic [SLOT_W-1:0] holdSlot_q;
  logic [CLKSLOT_W-1:0] holdClkSlot_q;
  logic holdLinear_q;
  logic holdPortSel_q;
  logic holdEnable_q;
  logic reqTgl_q;
  logic [2:0] ackSync_q;
  logic [2:0] frameSync_q;
  logic overrun_q;
  logic [FRAMECNT_W-1:0] frameCnt_q;
  logic codeRequest_q;
  logic busy;
  logic frameEvent;
  logic ctrlWrite;
  logic statusWrite;

  // Link domain signals read back in the system domain
  logic ackTgl_q;
  logic frameTgl_q;

  assign ctrlWrite = regWrite && (regAddr == ADDR_CTRL);
  assign statusWrite = regWrite && (regAddr == ADDR_STATUS);
  // A payload is in flight until the link echoes the request toggle
  assign busy = reqTgl_q != ackSync_q[1];
  // Frame toggle edge, taken between second and third stage
  assign frameEvent = frameSync_q[1] ^ frameSync_q[2];

  // Control register; the low bits steer slot placement and coding
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET[CTRL_USED_W-1:0];
    end else if (ctrlWrite) begin
      ctrl_q <= regWrData[CTRL_USED_W-1:0];
    end
  end

  // Filter and compressor control, registered one cycle after the control flops
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      compressorBypass <= 1'b0;
      balanceBypass <= 1'b0;
      responseBypass <= 1'b0;
      tx_gain_stageBypass <= 1'b0;
      highPassOff <= 1'b0;
    end else begin
      compressorBypass <= ctrl_q[LINEAR_BIT];
      balanceBypass <= ctrl_q[BAL_BYP_BIT];
      responseBypass <= ctrl_q[RESP_BYP_BIT];
      tx_gain_stageBypass <= ctrl_q[GAIN_BYP_BIT];
      highPassOff <= ctrl_q[HPF_OFF_BIT];
    end
  end

  // Read data valid in the cycle after the read strobe only
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdData_q <= READ_UNMAPPED;
    end else if (regRead) begin
      case (regAddr)
        ADDR_CTRL: begin
          rdData_q <= {{(32-CTRL_USED_W){1'b0}}, ctrl_q};
        end
        ADDR_STATUS: begin
          rdData_q <= {frameCnt_q, 14'h0000, overrun_q, busy};
        end
        default: begin
          rdData_q <= READ_UNMAPPED;
        end
      endcase
    end else begin
      rdData_q <= READ_UNMAPPED;
    end
  end
  assign regRdData = rdData_q;

  // Output register: code and its slot settings, frozen while in flight
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      holdCode_q <= '0;
      holdSlot_q <= '0;
      holdClkSlot_q <= '0;
      holdLinear_q <= 1'b0;
      holdPortSel_q <= 1'b0;
      holdEnable_q <= 1'b0;
      reqTgl_q <= 1'b0;
    end else if (codeValid && !busy) begin
      // Linear path skips the compressor; companded sits in the low byte
      holdCode_q <= ctrl_q[LINEAR_BIT] ? codeLinear
                  : {{(CODE_W-CMP_W){1'b0}}, codeCompanded};
      // Normal mode honours only the low five slot bits
      holdSlot_q <= ctrl_q[EXPANDED_BIT]
                  ? ctrl_q[SLOT_LSB +: SLOT_W]
                  : (ctrl_q[SLOT_LSB +: SLOT_W] & NORMAL_SLOT_MASK);
      holdClkSlot_q <= ctrl_q[CLKSLOT_LSB +: CLKSLOT_W];
      holdLinear_q <= ctrl_q[LINEAR_BIT];
      holdPortSel_q <= ctrl_q[PORTSEL_BIT];
      holdEnable_q <= ctrl_q[ENABLE_BIT];
      reqTgl_q <= ~reqTgl_q;
    end
  end

  // Overrun: a code offered while the previous one is still in flight.
  // Set wins over a software clear in the same cycle.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      overrun_q <= 1'b0;
    end else if (codeValid && busy) begin
      overrun_q <= 1'b1;
    end else if (statusWrite && regWrData[OVERRUN_BIT]) begin
      overrun_q <= 1'b0;
    end
  end

  // Synchronisers for the link's acknowledge and frame toggles
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ackSync_q <= '0;
      frameSync_q <= '0;
    end else begin
      ackSync_q <= {ackSync_q[1:0], ackTgl_q};
      frameSync_q <= {frameSync_q[1:0], frameTgl_q};
    end
  end

  // One code request per frame, plus a frame counter for software
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      codeRequest_q <= 1'b0;
      frameCnt_q <= '0;
    end else begin
      codeRequest_q <= frameEvent;
      if (frameEvent) begin
        frameCnt_q <= frameCnt_q + 1'b1;
      end
    end
  end
  assign codeRequest = codeRequest_q;

  // ---------------- Link (bit clock) domain ----------------
  logic [1:0] linkRst_q;
  logic linkRst;
  logic [2:0] reqSync_q;
  logic [PAY_W-1:0] stage_q;
  logic [PAY_W-1:0] active_q;
  logic [PAY_W-1:0] cfgNow;
  logic fsPrev_q;
  logic fsRise;
  logic [POS_W-1:0] pos_q;
  logic [POS_W-1:0] posNext;
  ptsi_link_state_type state_q;
  ptsi_link_state_type stateNext;
  logic [CODE_W-1:0] wordNow;
  logic [SLOT_W-1:0] slotNow;
  logic [CLKSLOT_W-1:0] clkSlotNow;
  logic linearNow;
  logic portSelNow;
  logic enableNow;
  logic [POS_W-1:0] bitsNow;
  logic [POS_W-1:0] slotStart;
  logic [POS_W-1:0] slotEnd;
  logic [IDX_W-1:0] bitIdx;
  logic [IDX_W-1:0] msbIdx;
  logic dataBit;
  logic [NUM_PORTS-1:0] drv_q;
  logic [NUM_PORTS-1:0] dat_q;
  // Strobes get flops of their own so no pin sees an inverter
  logic [NUM_PORTS-1:0] strobeN_q;

  // Reset carried into the link domain; it only releases on link edges
  always_ff @(posedge tx_bit_clock) begin
    linkRst_q <= {linkRst_q[0], rst};
  end
  assign linkRst = linkRst_q[1];

  // Request toggle crossing; payload is stable while the toggle differs
  always_ff @(posedge tx_bit_clock) begin
    if (linkRst) begin
      reqSync_q <= '0;
      ackTgl_q <= 1'b0;
      stage_q <= '0;
    end else begin
      reqSync_q <= {reqSync_q[1:0], reqTgl_q};
      if (reqSync_q[1] ^ reqSync_q[2]) begin
        stage_q <= {holdEnable_q, holdPortSel_q, holdLinear_q,
                    holdClkSlot_q, holdSlot_q, holdCode_q};
        ackTgl_q <= reqSync_q[1];
      end
    end
  end

  // Frame start: sync is synchronous to the bit clock, edge detected
  assign fsRise = tx_frame_sync && !fsPrev_q;

  // Staged code takes over only at a frame start, so a slot never
  // mixes two codes
  assign cfgNow = fsRise ? stage_q : active_q;
  assign wordNow = cfgNow[CODE_W-1:0];
  assign slotNow = cfgNow[CODE_W +: SLOT_W];
  assign clkSlotNow = cfgNow[CODE_W+SLOT_W +: CLKSLOT_W];
  assign linearNow = cfgNow[CODE_W+SLOT_W+CLKSLOT_W];
  assign portSelNow = cfgNow[CODE_W+SLOT_W+CLKSLOT_W+1];
  assign enableNow = cfgNow[CODE_W+SLOT_W+CLKSLOT_W+2];

  // Slot geometry from the bit count of the selected coding
  always_comb begin
    logic [SLOT_W-1:0] slotEff;
    // Mode masking is done at capture, so the link needs no mode bit
    // and the payload stays as narrow as before
    slotEff = slotNow;
    bitsNow = linearNow ? BITS_LINEAR : BITS_COMPANDED;
    slotStart = POS_W'(slotEff) * bitsNow
              + POS_W'(clkSlotNow);
    slotEnd = slotStart + bitsNow;
  end

  // Bit position since frame sync, saturating so long frames are safe
  // at the fastest bit clocks
  assign posNext = fsRise ? '0
                 : ((pos_q == POS_MAX) ? POS_MAX : pos_q + POS_ONE);

  always_ff @(posedge tx_bit_clock) begin
    if (linkRst) begin
      fsPrev_q <= 1'b0;
      pos_q <= '0;
      active_q <= '0;
    end else begin
      fsPrev_q <= tx_frame_sync;
      pos_q <= posNext;
      if (fsRise) begin
        active_q <= stage_q;
      end
    end
  end

  // Slot sequencer: wait for slot start, shift, then rest till next sync
  always_comb begin
    stateNext = state_q;
    case (state_q)
      LS_IDLE, LS_DONE, LS_WAIT: begin
        if (fsRise || state_q == LS_WAIT) begin
          if (!enableNow) begin
            stateNext = LS_DONE;
          end else if (posNext == slotStart) begin
            stateNext = LS_SHIFT;
          end else begin
            stateNext = LS_WAIT;
          end
        end
      end
      LS_SHIFT: begin
        if (fsRise) begin
          stateNext = (enableNow && posNext == slotStart) ? LS_SHIFT
                    : LS_WAIT;
        end else if (posNext == slotEnd) begin
          stateNext = LS_DONE;
        end
      end
      default: begin
        stateNext = LS_IDLE;
      end
    endcase
  end

  always_ff @(posedge tx_bit_clock) begin
    if (linkRst) begin
      state_q <= LS_IDLE;
    end else begin
      state_q <= stateNext;
    end
  end

  // Most significant bit first: index counts down from the top bit
  assign bitIdx = IDX_W'(posNext - slotStart);
  assign msbIdx = IDX_W'(bitsNow - POS_ONE);
  assign dataBit = wordNow[msbIdx - bitIdx];

  // Per-port drive: only the selected port is driven, only in the slot
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      always_ff @(posedge tx_bit_clock) begin
        if (linkRst) begin
          drv_q[gp] <= 1'b0;
          dat_q[gp] <= 1'b0;
          strobeN_q[gp] <= 1'b1;
        end else begin
          strobeN_q[gp] <= !((stateNext == LS_SHIFT)
                        && (portSelNow == gp[0]));
          drv_q[gp] <= (stateNext == LS_SHIFT)
                    && (portSelNow == gp[0]);
          dat_q[gp] <= (stateNext == LS_SHIFT)
                    && (portSelNow == gp[0]) && dataBit;
        end
      end
    end
  endgenerate

  // Strobe low exactly while the same port is driven
  assign pcm_out_port_a = dat_q[0];
  assign pcm_out_port_a_en = drv_q[0];
  assign slot_strobe_a_n = strobeN_q[0];
  assign pcm_out_port_b = dat_q[1];
  assign pcm_out_port_b_en = drv_q[1];
  assign slot_strobe_b_n = strobeN_q[1];

  // Frame toggle back to the system side for the per-frame request
  always_ff @(posedge tx_bit_clock) begin
    if (linkRst) begin
      frameTgl_q <= 1'b0;
    end else if (fsRise) begin
      frameTgl_q <= ~frameTgl_q;
    end
  end

endmodule : ptsi_tx_slot

`default_nettype wire

/* verification/pcm_transmit_slot_interface_tb.sv */
// Testbench: register access, slot placement and port choice end to end.
// Assumes the highway model supplies bit clock and frame sync.
`timescale 1ns/1ps
`default_nettype none
module pcm_transmit_slot_interface_tb import ptsi_pkg::*;;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [31:0] regWrData = '0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [31:0] regRdData;
  logic [CODE_W-1:0] codeLinear = '0;
  logic [CMP_W-1:0] codeCompanded = '0;
  logic codeValid = 1'b0;
  logic codeRequest, compressorBypass, balanceBypass, responseBypass;
  logic tx_gain_stageBypass, highPassOff, tx_bit_clock, tx_frame_sync;
  logic [1:0] en, dat, strobeN;
  logic [1:0][15:0] word;
  logic [1:0][10:0] start;
  logic [1:0][4:0] count;
  logic [31:0] v;
  int fails = 0;
  int checked = 0;
  realtime t1;
  always #5 clk_sys = ~clk_sys;
  ptsi_tx_slot i_ptsi_tx_slot (.clk_sys(clk_sys), .rst(rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .codeLinear(codeLinear),
    .codeCompanded(codeCompanded), .codeValid(codeValid),
    .codeRequest(codeRequest), .compressorBypass(compressorBypass),
    .balanceBypass(balanceBypass), .responseBypass(responseBypass),
    .tx_gain_stageBypass(tx_gain_stageBypass), .highPassOff(highPassOff),
    .tx_bit_clock(tx_bit_clock), .tx_frame_sync(tx_frame_sync),
    .pcm_out_port_a(dat[0]), .pcm_out_port_a_en(en[0]),
    .slot_strobe_a_n(strobeN[0]), .pcm_out_port_b(dat[1]),
    .pcm_out_port_b_en(en[1]), .slot_strobe_b_n(strobeN[1]));
  ptsi_highway_model i_ptsi_highway_model (.tx_bit_clock(tx_bit_clock),
    .tx_frame_sync(tx_frame_sync), .portEn(en), .portDat(dat),
    .lastWord(word), .lastStart(start), .lastCount(count));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 v = regRdData;
  endtask : rd
  // Wait for a frame request, optionally answer with a code
  task automatic frame(input logic give, input logic [15:0] code);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (codeRequest !== 1'b1 && n < 1000);
    chk(n < 1000, 1'b1);
    if (give) begin
      codeLinear <= code;
      codeCompanded <= code[7:0];
      codeValid <= 1'b1;
      @(posedge clk_sys);
      codeValid <= 1'b0;
    end
  endtask : frame
  task automatic run(input logic [5:0] s, input logic [2:0] c,
    input logic lin, input logic p, input logic e, input logic x,
    input logic [15:0] code);
    logic [10:0] bits;
    logic [5:0] slot;
    bits = lin ? BITS_LINEAR : BITS_COMPANDED;
    // Normal mode keeps only five slot bits, expanded mode all six
    slot = x ? s : {1'b0, s[4:0]};
    wr(ADDR_CTRL, {16'h0000, e, p, x, lin, 1'b0, c, 2'b00, s});
    frame(1'b1, code);
    t1 = $realtime;
    frame(1'b1, code);
    chk(($realtime - t1) > 6220 && ($realtime - t1) < 6260, 1'b1);
    frame(1'b0, code);
    chk(count[p], e ? bits : 11'h000);
    chk(count[!p], 5'h00);
    if (e) begin
      chk(word[p], lin ? code : {8'h00, code[7:0]});
      chk(start[p], slot * bits + c);
    end
    chk(compressorBypass, lin);
    $display("test slot %0d clk %0d lin %0d done", s, c, lin);
  endtask : run
  task automatic close_out();
    $display("compares %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  // Watchdog well past the expected run of about 12000 cycles
  initial begin
    repeat (60000) @(posedge clk_sys);
    fails++;
    close_out();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rd(ADDR_CTRL);
    chk(v, CTRL_RESET);
    rd(4'h8);
    chk(v, READ_UNMAPPED);
    wr(ADDR_CTRL, 32'h000a_0000);
    rd(ADDR_CTRL);
    chk(v, 32'h000a_0000);
    chk({balanceBypass, responseBypass, tx_gain_stageBypass}, 3'b010);
    chk(highPassOff, 1'b1);
    wr(ADDR_CTRL, 32'h0005_0000);
    rd(ADDR_CTRL);
    chk(v, 32'h0005_0000);
    chk({balanceBypass, responseBypass, tx_gain_stageBypass}, 3'b101);
    chk(highPassOff, 1'b0);
    // Nothing staged yet, so both strobes must still be idle
    chk(strobeN, 2'b11);
    $display("test registers done");
    run(6'h00, 3'h0, 1'b0, 1'b0, 1'b1, 1'b0, 16'h00a5);
    run(6'h03, 3'h5, 1'b1, 1'b1, 1'b1, 1'b0, 16'h9c36);
    run(6'h3f, 3'h7, 1'b0, 1'b0, 1'b1, 1'b1, 16'h003c);
    run(6'h1f, 3'h2, 1'b1, 1'b0, 1'b1, 1'b0, 16'h8001);
    run(6'h05, 3'h1, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0055);
    // Top slot bit set in normal mode: only the low five bits count
    run(6'h22, 3'h4, 1'b0, 1'b1, 1'b1, 1'b0, 16'h00c3);
    // Second offer while busy must flag an overrun
    frame(1'b0, 16'h0000);
    codeValid <= 1'b1;
    repeat (2) @(posedge clk_sys);
    codeValid <= 1'b0;
    rd(ADDR_STATUS);
    chk(v[OVERRUN_BIT], 1'b1);
    wr(ADDR_STATUS, 32'h0000_0002);
    rd(ADDR_STATUS);
    chk(v[OVERRUN_BIT], 1'b0);
    $display("test overrun done");
    close_out();
  end
endmodule : pcm_transmit_slot_interface_tb
`default_nettype wire

/* verification/ptsi_highway_model.sv */
// Highway model: bit clock, frame sync, per-frame capture of both ports.
// Assumes the slot interface drives data and enables on the bit clock.
`timescale 1ns/1ps
`default_nettype none
module ptsi_highway_model #(
  parameter int FRAME_BITS = 1040
) (
  output logic tx_bit_clock,
  output logic tx_frame_sync,
  input wire logic [1:0] portEn,
  input wire logic [1:0] portDat,
  output logic [1:0][15:0] lastWord,
  output logic [1:0][10:0] lastStart,
  output logic [1:0][4:0] lastCount
);
  logic [10:0] cnt = 11'h001;
  logic [10:0] pos = 11'h000;
  logic syncPrev = 1'b0;
  logic [1:0][15:0] word = '0;
  logic [1:0][10:0] start = '0;
  logic [1:0][4:0] count = '0;
  // Highway bit clock runs continuously; odd phase against clk_sys
  initial begin
    tx_bit_clock = 1'b0;
    tx_frame_sync = 1'b0;
    #1.7;
    forever #3 tx_bit_clock = ~tx_bit_clock;
  end
  // One-period sync at the top of every frame
  always @(posedge tx_bit_clock) begin
    cnt <= (cnt == FRAME_BITS - 1) ? 11'h000 : cnt + 11'h001;
    tx_frame_sync <= (cnt == 11'h000);
  end
  // Capture driven bits; hand over a frame's results at the next sync
  always @(posedge tx_bit_clock) begin
    pos = (tx_frame_sync && !syncPrev) ? 11'h000 : pos + 11'h001;
    for (int i = 0; i < 2; i++) begin
      if (portEn[i]) begin
        if (count[i] == 5'h00) begin
          start[i] = pos - 11'h001;
        end
        word[i] = {word[i][14:0], portDat[i]};
        count[i] = count[i] + 5'h01;
      end
    end
    if (tx_frame_sync && !syncPrev) begin
      lastWord <= word;
      lastStart <= start;
      lastCount <= count;
      word = '0;
      count = '0;
    end
    syncPrev = tx_frame_sync;
  end
endmodule : ptsi_highway_model
`default_nettype wire

/* verification/ptsi_tx_slot_chk.sv */
// Checker: port-level properties of the transmit slot interface.
// Assumes it is bound into every ptsi_tx_slot instance.
`timescale 1ns/1ps
`default_nettype none
module ptsi_tx_slot_chk
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic regRead,
  input wire logic [31:0] regRdData,
  input wire logic codeRequest,
  input wire logic tx_bit_clock,
  input wire logic pcm_out_port_a,
  input wire logic pcm_out_port_a_en,
  input wire logic slot_strobe_a_n,
  input wire logic pcm_out_port_b,
  input wire logic pcm_out_port_b_en,
  input wire logic slot_strobe_b_n
);
  logic [4:0] runLen_q;
  logic anyEn;
  assign anyEn = pcm_out_port_a_en | pcm_out_port_b_en;
  // Burst length; a stuck enable shows up as a wrong count
  always_ff @(posedge tx_bit_clock) begin
    if (rst || !anyEn) begin
      runLen_q <= 5'h00;
    end else begin
      runLen_q <= runLen_q + 5'h01;
    end
  end
  a_strobe_a_match: assert property (
    @(posedge tx_bit_clock) disable iff (rst)
    slot_strobe_a_n == !pcm_out_port_a_en) else $error("strobe a wrong");
  a_strobe_b_match: assert property (
    @(posedge tx_bit_clock) disable iff (rst)
    slot_strobe_b_n == !pcm_out_port_b_en) else $error("strobe b wrong");
  a_one_port: assert property (
    @(posedge tx_bit_clock) disable iff (rst)
    !(pcm_out_port_a_en && pcm_out_port_b_en)) else $error("both ports on");
  a_idle_a_low: assert property (
    @(posedge tx_bit_clock) disable iff (rst)
    !pcm_out_port_a_en |-> !pcm_out_port_a) else $error("idle data a");
  a_idle_b_low: assert property (
    @(posedge tx_bit_clock) disable iff (rst)
    !pcm_out_port_b_en |-> !pcm_out_port_b) else $error("idle data b");
  a_burst_len: assert property (
    @(posedge tx_bit_clock) disable iff (rst)
    (runLen_q != 5'h00 && !anyEn) |-> (runLen_q inside {5'h08, 5'h10}))
    else $error("burst length wrong");
  a_req_spaced: assert property (
    @(posedge clk_sys) disable iff (rst)
    codeRequest |=> !codeRequest [*8]) else $error("request too close");
  a_rd_gap: assert property (
    @(posedge clk_sys) disable iff (rst)
    !$past(regRead) |-> regRdData == 32'h0000_0000)
    else $error("stray read data");
  c_linear: cover property (@(posedge tx_bit_clock)
    runLen_q == 5'h10 && !anyEn);
  c_port_b: cover property (@(posedge tx_bit_clock) pcm_out_port_b_en);
  c_read: cover property (@(posedge clk_sys) regRead);
endmodule : ptsi_tx_slot_chk

bind ptsi_tx_slot ptsi_tx_slot_chk i_ptsi_tx_slot_chk (
  .clk_sys(clk_sys), .rst(rst), .regRead(regRead), .regRdData(regRdData),
  .codeRequest(codeRequest), .tx_bit_clock(tx_bit_clock),
  .pcm_out_port_a(pcm_out_port_a), .pcm_out_port_a_en(pcm_out_port_a_en),
  .slot_strobe_a_n(slot_strobe_a_n), .pcm_out_port_b(pcm_out_port_b),
  .pcm_out_port_b_en(pcm_out_port_b_en), .slot_strobe_b_n(slot_strobe_b_n));
`default_nettype wire
